// ==== verilog/pcc_cap_bank.sv ====
// per-port capability registers: power management, message interrupt, product data window,
// vendor header, test registers and replay timeout override.
// assumes a single-cycle config access port on clk, an eeprom engine on clk that answers
// ee_req with one ee_done pulse, and an upstream-port strap pin from outside the clock domain.

`timescale 1ns/1ps
`default_nettype none

`include "pcc_map.svh"

module pcc_cap_bank
   import pcc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic port_is_upstream,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   input wire logic ovr_load,
   input wire logic [10:0] ovr_pm_cap_hi,
   input wire logic ovr_no_soft_reset,
   input wire logic [14:0] ovr_replay,
   output logic ee_req,
   output logic ee_write,
   output logic [5:0] ee_index,
   output logic [31:0] ee_wdata,
   input wire logic ee_done,
   input wire logic [31:0] ee_rdata,
   output logic [1:0] pm_state,
   output logic pm_event_enable,
   output logic hot_reset,
   output logic internal_reset,
   output logic downstream_reset_out_n,
   output logic msi_enable,
   output logic intx_allowed,
   output logic [31:0] msi_addr_low,
   output logic [31:0] msi_addr_high,
   output logic [15:0] msi_data,
   output logic [11:0] replay_timeout,
   output logic [31:0] phy_test_control_0,
   output logic [31:0] phy_test_control_1
);

   function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : bmerge

   function automatic logic wr_hit(input logic [7:0] off);
      return cfg_wr && (cfg_addr == off);
   endfunction : wr_hit

   // strap synchroniser: first stage feeds only the second
   logic up_meta_reg;
   logic up_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         up_meta_reg <= 1'b0;
         up_reg <= 1'b0;
      end else begin
         up_meta_reg <= port_is_upstream;
         up_reg <= up_meta_reg;
      end
   end

   // overridable advertisement and timer fields
   logic [10:0] pm_cap_hi_reg;
   logic nsr_reg;
   logic [1:0] cap_dis_reg;
   logic [11:0] replay_val_reg;
   logic replay_en_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pm_cap_hi_reg <= `PCC_PM_CAP_HI_RST;
         nsr_reg <= `PCC_NSR_RST;
         cap_dis_reg <= 2'h0;
         replay_val_reg <= 12'h000;
         replay_en_reg <= 1'b0;
      end else if (ovr_load) begin
         // loaded values win over a same-cycle software write
         pm_cap_hi_reg <= ovr_pm_cap_hi;
         nsr_reg <= ovr_no_soft_reset;
         cap_dis_reg <= ovr_replay[14:13];
         replay_val_reg <= ovr_replay[11:0];
         replay_en_reg <= ovr_replay[`PCC_BIT_REPLAY_EN];
      end else if (wr_hit(`PCC_OFF_REPLAY)) begin
         if (cfg_be[0]) begin
            replay_val_reg[7:0] <= cfg_wdata[7:0];
         end
         if (cfg_be[1]) begin
            replay_val_reg[11:8] <= cfg_wdata[11:8];
            replay_en_reg <= cfg_wdata[`PCC_BIT_REPLAY_EN];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         replay_timeout <= `PCC_REPLAY_DEFAULT;
      end else begin
         replay_timeout <= replay_en_reg ? replay_val_reg : `PCC_REPLAY_DEFAULT;
      end
   end

   // power state and the reset it triggers; decode spelled out so the net follows every operand
   logic pm_d0_from_d3;
   assign pm_d0_from_d3 = cfg_wr && (cfg_addr == `PCC_OFF_PM_CSR) && cfg_be[0]
                          && (cfg_wdata[1:0] == `PCC_PM_D0) && (pm_state == `PCC_PM_D3HOT);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pm_state <= `PCC_PM_D0;
         hot_reset <= 1'b0;
         internal_reset <= 1'b0;
         downstream_reset_out_n <= 1'b1;
      end else begin
         if (wr_hit(`PCC_OFF_PM_CSR) && cfg_be[0]) begin
            pm_state <= cfg_wdata[1:0];
         end
         hot_reset <= pm_d0_from_d3;
         internal_reset <= pm_d0_from_d3 && !nsr_reg;
         // the port-level hot reset never drives the downstream reset pin
         downstream_reset_out_n <= 1'b1;
      end
   end

   // event enable is sticky: only the port reset clears it, the hot reset does not
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pm_event_enable <= 1'b0;
      end else if (wr_hit(`PCC_OFF_PM_CSR) && cfg_be[1]) begin
         pm_event_enable <= cfg_wdata[`PCC_BIT_PME_EN];
      end
   end

   // message interrupt block, writable on downstream ports only
   logic [2:0] msi_mme_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         msi_enable <= 1'b0;
         msi_mme_reg <= 3'h0;
         msi_addr_low <= `PCC_ZERO32;
         msi_addr_high <= `PCC_ZERO32;
         msi_data <= 16'h0000;
      end else if (!up_reg) begin
         if (wr_hit(`PCC_OFF_MSI_CTL) && cfg_be[2]) begin
            msi_enable <= cfg_wdata[`PCC_BIT_MSI_EN];
            msi_mme_reg <= cfg_wdata[22:20];
         end
         if (wr_hit(`PCC_OFF_MSI_ADDR_LO)) begin
            msi_addr_low <= bmerge(msi_addr_low, {cfg_wdata[31:2], 2'h0}, cfg_be);
         end
         if (wr_hit(`PCC_OFF_MSI_ADDR_HI)) begin
            msi_addr_high <= bmerge(msi_addr_high, cfg_wdata, cfg_be);
         end
         if (wr_hit(`PCC_OFF_MSI_DATA)) begin
            msi_data <= 16'(bmerge({16'h0000, msi_data}, cfg_wdata, cfg_be));
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         intx_allowed <= 1'b1;
      end else begin
         intx_allowed <= !msi_enable;
      end
   end

   // test registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phy_test_control_0 <= `PCC_PHY_TEST0_RST;
         phy_test_control_1 <= `PCC_PHY_TEST1_RST;
      end else begin
         if (wr_hit(`PCC_OFF_PHY_TEST0)) begin
            phy_test_control_0 <= bmerge(phy_test_control_0, cfg_wdata, cfg_be);
         end
         if (wr_hit(`PCC_OFF_PHY_TEST1)) begin
            phy_test_control_1 <= bmerge(phy_test_control_1, cfg_wdata, cfg_be);
         end
      end
   end

   // product-data window, upstream port only
   pcc_vpd_state_t vpd_state_reg;
   logic [5:0] vpd_index_reg;
   logic vpd_op_reg;
   logic [31:0] product_data_word_reg;
   logic vpd_start;
   logic [5:0] vpd_index_next;
   assign vpd_start = up_reg && (vpd_state_reg == PCC_VPD_IDLE)
                      && cfg_wr && (cfg_addr == `PCC_OFF_VPD_CMD) && cfg_be[3];
   // the index written in the same access is the one used by the cycle
   assign vpd_index_next = cfg_be[2] ? cfg_wdata[23:18] : vpd_index_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vpd_state_reg <= PCC_VPD_IDLE;
         vpd_index_reg <= 6'h00;
         vpd_op_reg <= 1'b0;
         ee_req <= 1'b0;
         ee_write <= 1'b0;
         ee_index <= 6'h00;
         ee_wdata <= `PCC_ZERO32;
      end else begin
         case (vpd_state_reg)
            PCC_VPD_IDLE: begin
               if (up_reg && wr_hit(`PCC_OFF_VPD_CMD) && cfg_be[2]) begin
                  vpd_index_reg <= cfg_wdata[23:18];
               end
               if (vpd_start) begin
                  vpd_op_reg <= cfg_wdata[`PCC_BIT_VPD_OP];
                  ee_req <= 1'b1;
                  ee_write <= cfg_wdata[`PCC_BIT_VPD_OP];
                  ee_index <= vpd_index_next;
                  ee_wdata <= product_data_word_reg;
                  vpd_state_reg <= PCC_VPD_BUSY;
               end
            end
            PCC_VPD_BUSY: begin
               // commands written while a cycle runs are dropped
               if (ee_done) begin
                  ee_req <= 1'b0;
                  vpd_op_reg <= !ee_write;
                  vpd_state_reg <= PCC_VPD_IDLE;
               end
            end
            default: begin
               vpd_state_reg <= PCC_VPD_IDLE;
               ee_req <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         product_data_word_reg <= `PCC_ZERO32;
      end else if (vpd_state_reg == PCC_VPD_BUSY && ee_done && !ee_write) begin
         product_data_word_reg <= ee_rdata;
      end else if (up_reg && vpd_state_reg == PCC_VPD_IDLE && wr_hit(`PCC_OFF_PRODUCT_DATA_WORD)) begin
         product_data_word_reg <= bmerge(product_data_word_reg, cfg_wdata, cfg_be);
      end
   end

   // read path, one cycle after the request
   logic [31:0] rd_word;
   always_comb begin
      rd_word = `PCC_ZERO32;
      case (cfg_addr)
         `PCC_OFF_PM_CAP: rd_word = {pm_cap_hi_reg, 2'h0, `PCC_PM_REV,
                                     up_reg ? `PCC_NEXT_PM_UP : `PCC_NEXT_PM_DN,
                                     `PCC_ID_PM};
         // event status bit 15 and reserved bits stay zero
         `PCC_OFF_PM_CSR: rd_word = {16'h0000, 7'h00, pm_event_enable, 4'h0, nsr_reg, 1'b0,
                                     pm_state};
         `PCC_OFF_MSI_CTL: rd_word = up_reg ? `PCC_ZERO32 :
                                     {8'h00, 1'b1, msi_mme_reg, 3'h0, msi_enable,
                                      `PCC_NEXT_TO_VENDOR, `PCC_ID_MSI};
         `PCC_OFF_MSI_ADDR_LO: rd_word = up_reg ? `PCC_ZERO32 : msi_addr_low;
         `PCC_OFF_MSI_ADDR_HI: rd_word = up_reg ? `PCC_ZERO32 : msi_addr_high;
         `PCC_OFF_MSI_DATA: rd_word = up_reg ? `PCC_ZERO32 : {16'h0000, msi_data};
         `PCC_OFF_VPD_CMD: rd_word = !up_reg ? `PCC_ZERO32 :
                                     {vpd_op_reg, 7'h00, vpd_index_reg, 2'h0,
                                      `PCC_NEXT_TO_VENDOR, `PCC_ID_VPD};
         `PCC_OFF_PRODUCT_DATA_WORD: rd_word = up_reg ? product_data_word_reg : `PCC_ZERO32;
         `PCC_OFF_VENDOR: rd_word = {`PCC_VENDOR_LEN, `PCC_NEXT_VENDOR,
                                     `PCC_ID_VENDOR};
         `PCC_OFF_PHY_TEST0: rd_word = phy_test_control_0;
         `PCC_OFF_PHY_TEST1: rd_word = phy_test_control_1;
         `PCC_OFF_REPLAY: rd_word = {17'h00000, cap_dis_reg, replay_en_reg, replay_val_reg};
         default: rd_word = `PCC_ZERO32;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_rdata <= `PCC_ZERO32;
         cfg_rvalid <= 1'b0;
      end else begin
         cfg_rdata <= cfg_rd ? rd_word : `PCC_ZERO32;
         cfg_rvalid <= cfg_rd;
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_pm_cap_id: assert property (cfg_rd && cfg_addr == `PCC_OFF_PM_CAP |=>
      cfg_rvalid && cfg_rdata[7:0] == `PCC_ID_PM && cfg_rdata[18:16] == `PCC_PM_REV)
      else $error("power capability id or revision wrong");
   a_pm_next_ptr: assert property (cfg_rd && cfg_addr == `PCC_OFF_PM_CAP && up_reg |=>
      cfg_rdata[15:8] == `PCC_NEXT_PM_UP)
      else $error("upstream power next pointer wrong");
   a_pm_status_zero: assert property (cfg_rd && cfg_addr == `PCC_OFF_PM_CSR |=>
      !cfg_rdata[15] && cfg_rdata[1:0] == $past(pm_state))
      else $error("power status read wrong");
   a_hot_reset_d3: assert property (pm_d0_from_d3 |=> hot_reset
      && pm_state == `PCC_PM_D0 && downstream_reset_out_n ##1 !hot_reset)
      else $error("hot reset from D3hot wrong");
   a_soft_reset_gate: assert property (pm_d0_from_d3 && nsr_reg |=> !internal_reset)
      else $error("internal reset despite skip flag");
   a_intx_block: assert property ($rose(msi_enable) |=> !intx_allowed)
      else $error("legacy interrupt still allowed");
   a_vpd_read_done: assert property (vpd_state_reg == PCC_VPD_BUSY && ee_done
      && !ee_write |=> vpd_op_reg && product_data_word_reg == $past(ee_rdata) && !ee_req)
      else $error("product-data read completion wrong");
   a_vpd_write_done: assert property (vpd_state_reg == PCC_VPD_BUSY && ee_done
      && ee_write |=> !vpd_op_reg && !ee_req)
      else $error("product-data write completion wrong");
   a_vpd_start: assert property (vpd_start |=> ee_req
      && ee_index == $past(vpd_index_next) && ee_wdata == $past(product_data_word_reg))
      else $error("product-data cycle start wrong");
   a_replay_sel: assert property (replay_en_reg [*2] |->
      replay_timeout == $past(replay_val_reg))
      else $error("user replay timeout not used");

   c_vpd_read: cover property (vpd_start && !cfg_wdata[`PCC_BIT_VPD_OP] ##[1:20] ee_done);
   c_vpd_write: cover property (vpd_start && cfg_wdata[`PCC_BIT_VPD_OP] ##[1:20] ee_done);
   c_hot_reset: cover property (hot_reset && internal_reset);
   c_msi_on: cover property ($rose(msi_enable));

endmodule : pcc_cap_bank

`default_nettype wire

// ==== shared/pcc_map.svh ====
// register offsets, field positions, fixed codes and reset values of the port capability bank
// included by the bank itself and by the self-checking bench
`ifndef PCC_MAP_SVH
`define PCC_MAP_SVH

`define PCC_OFF_PM_CAP 8'h40
`define PCC_OFF_PM_CSR 8'h44
`define PCC_OFF_MSI_CTL 8'h4C
`define PCC_OFF_MSI_ADDR_LO 8'h50
`define PCC_OFF_MSI_ADDR_HI 8'h54
`define PCC_OFF_MSI_DATA 8'h58
`define PCC_OFF_VPD_CMD 8'h5C
`define PCC_OFF_PRODUCT_DATA_WORD 8'h60
`define PCC_OFF_VENDOR 8'h64
`define PCC_OFF_PHY_TEST0 8'h68
`define PCC_OFF_PHY_TEST1 8'h6C
`define PCC_OFF_REPLAY 8'h70

`define PCC_ID_PM 8'h01
`define PCC_ID_MSI 8'h05
`define PCC_ID_VPD 8'h03
`define PCC_ID_VENDOR 8'h09
`define PCC_NEXT_PM_UP 8'h5C
`define PCC_NEXT_PM_DN 8'h4C
`define PCC_NEXT_TO_VENDOR 8'h64
`define PCC_NEXT_VENDOR 8'hB0
`define PCC_VENDOR_LEN 16'h0034
`define PCC_PM_REV 3'h3
`define PCC_PM_CAP_HI_RST 11'h7FE
`define PCC_NSR_RST 1'h1
`define PCC_PHY_TEST0_RST 32'h04001060
`define PCC_PHY_TEST1_RST 32'h04000800
`define PCC_REPLAY_DEFAULT 12'h0C0
`define PCC_ZERO32 32'h00000000

`define PCC_PM_D0 2'h0
`define PCC_PM_D3HOT 2'h3

`define PCC_BIT_PME_EN 8
`define PCC_BIT_MSI_EN 16
`define PCC_BIT_VPD_OP 31
`define PCC_BIT_REPLAY_EN 12

`endif

// ==== shared/pcc_pkg.sv ====
// types shared by the port capability bank
// offsets and codes come from pcc_map.svh
package pcc_pkg;
   typedef enum logic [0:0] {PCC_VPD_IDLE, PCC_VPD_BUSY} pcc_vpd_state_t;
   typedef logic [1:0] pcc_pstate_t;
endpackage : pcc_pkg

// ==== verif/pcc_ee_model.sv ====
// serial table store model answering the bank's eeprom request handshake
// assumes ee_req and its qualifiers are held until the edge after ee_done
`timescale 1ns/1ps
`default_nettype none

module pcc_ee_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic ee_req,
   input wire logic ee_write,
   input wire logic [5:0] ee_index,
   input wire logic [31:0] ee_wdata,
   input wire logic [7:0] ee_wait,
   output logic ee_done,
   output logic [31:0] ee_rdata
);
   logic [31:0] mem [0:63];
   logic [7:0] cnt;
   logic served;

   initial begin
      for (int i = 0; i < 64; i++) begin
         mem[i] = 32'hC0DE0000 | i;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ee_done <= 1'b0;
         cnt <= 8'h00;
         served <= 1'b0;
         ee_rdata <= 32'h5A5A5A5A;
      end else begin
         ee_done <= 1'b0;
         // read data is not held after the answer cycle
         ee_rdata <= ~ee_rdata;
         if (!ee_req) begin
            served <= 1'b0;
            cnt <= 8'h00;
         end else if (!served) begin
            if (cnt < ee_wait) begin
               cnt <= cnt + 8'h01;
            end else begin
               ee_done <= 1'b1;
               served <= 1'b1;
               if (ee_write) begin
                  mem[ee_index] <= ee_wdata;
               end else begin
                  ee_rdata <= mem[ee_index];
               end
            end
         end
      end
   end
endmodule : pcc_ee_model

`default_nettype wire

// ==== verif/tb_port_capability_config_space.sv ====
// self-checking bench: register model with masks compared at every read and output
// assumes the map header and the eeprom model beside the bank
`timescale 1ns/1ps
`default_nettype none
`include "pcc_map.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
   $display("unexpected at %0t got %h exp %h", $time, g, e); end end

module tb_port_capability_config_space;
   import pcc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic port_is_upstream = 1'b1;
   logic cfg_wr = 1'b0;
   logic cfg_rd = 1'b0;
   logic [7:0] cfg_addr = 8'h00;
   logic [3:0] cfg_be = 4'h0;
   logic [31:0] cfg_wdata = 32'h0;
   logic ovr_load = 1'b0;
   logic [10:0] ovr_pm_cap_hi = 11'h7FE;
   logic ovr_no_soft_reset = 1'b1;
   logic [14:0] ovr_replay = 15'h0;
   logic [7:0] ee_wait = 8'h00;
   logic [31:0] cfg_rdata, ee_wdata, ee_rdata, msi_addr_low, msi_addr_high;
   logic [31:0] phy_test_control_0, phy_test_control_1;
   logic cfg_rvalid, ee_req, ee_write, ee_done, pm_event_enable, hot_reset, internal_reset;
   logic downstream_reset_out_n, msi_enable, intx_allowed;
   logic [5:0] ee_index;
   logic [1:0] pm_state;
   logic [15:0] msi_data;
   logic [11:0] replay_timeout;
   logic [31:0] mreg [0:12];
   logic [31:0] wm [0:12];
   logic [31:0] eem [0:63];
   logic [31:0] seed = 32'd11582;
   logic [31:0] d;
   logic [7:0] a;
   int miscompares = 0;
   int n_compared = 0;

   pcc_cap_bank dut_u (.clk, .rst, .port_is_upstream, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
      .cfg_wdata, .cfg_rdata, .cfg_rvalid, .ovr_load, .ovr_pm_cap_hi, .ovr_no_soft_reset,
      .ovr_replay, .ee_req, .ee_write, .ee_index, .ee_wdata, .ee_done, .ee_rdata, .pm_state,
      .pm_event_enable, .hot_reset, .internal_reset, .downstream_reset_out_n, .msi_enable,
      .intx_allowed, .msi_addr_low, .msi_addr_high, .msi_data, .replay_timeout,
      .phy_test_control_0, .phy_test_control_1);
   pcc_ee_model ee_u (.clk, .rst, .ee_req, .ee_write, .ee_index, .ee_wdata, .ee_wait,
      .ee_done, .ee_rdata);

   always #25 clk = ~clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic final_report();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic do_reset(logic u);
      @(posedge clk);
      rst <= 1'b1;
      port_is_upstream <= u;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 13; i++) begin
         mreg[i] = 32'h0;
         wm[i] = 32'h0;
      end
      for (int i = 0; i < 64; i++) eem[i] = 32'hC0DE0000 | i;
      mreg[0] = {11'h7FE, 5'h03, u ? 8'h5C : 8'h4C, 8'h01};
      mreg[1] = 32'h8;
      wm[1] = 32'h103;
      if (u) begin
         mreg[7] = 32'h6403;
         wm[7] = 32'h80FC0000;
         wm[8] = 32'hFFFFFFFF;
      end else begin
         mreg[3] = 32'h00806405;
         wm[3] = 32'h710000;
         wm[4] = 32'hFFFFFFFC;
         wm[5] = 32'hFFFFFFFF;
         wm[6] = 32'hFFFF;
      end
      mreg[9] = 32'h0034B009;
      mreg[10] = 32'h04001060;
      mreg[11] = 32'h04000800;
      wm[10] = 32'hFFFFFFFF;
      wm[11] = 32'hFFFFFFFF;
      wm[12] = 32'h1FFF;
      // the strap needs two edges before the first access
      tick(3);
   endtask : do_reset

   task automatic cfg_write(logic [7:0] wa, logic [3:0] be, logic [31:0] wd);
      logic [31:0] m;
      int k;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      k = int'((wa - 8'h40) >> 2);
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_addr <= wa;
      cfg_be <= be;
      cfg_wdata <= wd;
      @(posedge clk);
      cfg_wr <= 1'b0;
      if (wa >= 8'h40 && wa <= 8'h70) mreg[k] = (mreg[k] & ~(m & wm[k])) | (wd & m & wm[k]);
      #1;
   endtask : cfg_write

   task automatic rd_chk(logic [7:0] ra);
      logic [31:0] e;
      e = (ra >= 8'h40 && ra <= 8'h70) ? mreg[int'((ra - 8'h40) >> 2)] : 32'h0;
      @(posedge clk);
      cfg_rd <= 1'b1;
      cfg_addr <= ra;
      @(posedge clk);
      cfg_rd <= 1'b0;
      #1;
      for (int i = 0; i < 2 && cfg_rvalid !== 1'b1; i++) tick(1);
      if (cfg_rvalid !== 1'b1) begin
         miscompares++;
         final_report();
      end
      `CHK(cfg_rdata, e)
   endtask : rd_chk

   task automatic wake();
      cfg_write(8'h44, 4'h1, 32'h3);
      cfg_write(8'h44, 4'h1, 32'h0);
      `CHK({hot_reset, internal_reset}, {1'b1, ~mreg[1][3]})
      `CHK(downstream_reset_out_n, 1'b1)
      tick(1);
      `CHK(hot_reset, 1'b0)
   endtask : wake

   task automatic vpd(logic [5:0] idx, logic op, logic [7:0] w);
      ee_wait = w;
      cfg_write(8'h5C, 4'hC, {op, 7'h0, idx, 18'h0});
      for (int i = 0; i < 3 && ee_req !== 1'b1; i++) tick(1);
      `CHK({ee_req, ee_write, ee_index}, {1'b1, op, idx})
      if (op) `CHK(ee_wdata, mreg[8])
      // a data write while busy must be dropped, so the model is put back
      cfg_write(8'h60, 4'hF, ~mreg[8]);
      mreg[8] = ~mreg[8];
      for (int i = 0; i < 300 && ee_req !== 1'b0; i++) tick(1);
      if (ee_req !== 1'b0) begin
         miscompares++;
         final_report();
      end
      mreg[7][31] = ~op;
      if (op) eem[idx] = mreg[8];
      else mreg[8] = eem[idx];
      rd_chk(8'h5C);
      rd_chk(8'h60);
   endtask : vpd

   initial begin
      do_reset(1'b1);
      `CHK({downstream_reset_out_n, intx_allowed, replay_timeout}, {2'b11, 12'h0C0})
      for (a = 8'h3C; a <= 8'h48; a += 8'h4) begin
         rd_chk(a);
      end
      for (a = 8'h4C; a <= 8'h74; a += 8'h4) begin
         rd_chk(a);
      end
      for (int i = 0; i < 4; i++) begin
         cfg_write(8'h44, 4'h1, 32'(i));
         `CHK({pm_state, hot_reset}, {2'(i), 1'b0})
      end
      cfg_write(8'h44, 4'hF, 32'hFFFF_81F3);
      `CHK({pm_state, pm_event_enable}, 3'b111)
      rd_chk(8'h44);
      wake();
      for (int i = 0; i < 9; i++) begin
         a = 8'h68 + 8'(i % 3) * 8'h4;
         cfg_write(a, 4'(rnd()), rnd());
         rd_chk(a);
      end
      `CHK({phy_test_control_0, phy_test_control_1}, {mreg[10], mreg[11]})
      `CHK(replay_timeout, mreg[12][12] ? mreg[12][11:0] : 12'h0C0)
      cfg_write(8'h70, 4'h3, 32'h1ABC);
      tick(1);
      `CHK(replay_timeout, 12'hABC)
      cfg_write(8'h60, 4'hF, rnd());
      vpd(6'd63, 1'b1, 8'd0);
      vpd(6'd63, 1'b0, 8'd20);
      vpd(6'd5, 1'b0, 8'd6);
      cfg_write(8'h5C, 4'h7, 32'hFFFFFFFF);
      tick(2);
      `CHK(ee_req, 1'b0)
      rd_chk(8'h5C);
      do_reset(1'b0);
      for (a = 8'h3C; a <= 8'h74; a += 8'h4) begin
         rd_chk(a);
      end
      cfg_write(8'h4C, 4'hF, 32'hFF81FFFF);
      tick(1);
      `CHK({msi_enable, intx_allowed}, 2'b10)
      for (a = 8'h50; a <= 8'h58; a += 8'h4) begin
         cfg_write(a, 4'hF, rnd());
         rd_chk(a);
      end
      `CHK({msi_addr_high, msi_addr_low}, {mreg[5], mreg[4]})
      `CHK(msi_data, mreg[6][15:0])
      cfg_write(8'h4C, 4'h4, 32'h0);
      tick(1);
      `CHK({msi_enable, intx_allowed}, 2'b01)
      cfg_write(8'h5C, 4'hF, 32'h80FC0000);
      tick(2);
      `CHK(ee_req, 1'b0)
      rd_chk(8'h5C);
      @(posedge clk);
      ovr_load <= 1'b1;
      ovr_pm_cap_hi <= 11'(rnd());
      ovr_no_soft_reset <= 1'b0;
      ovr_replay <= 15'(rnd()) | 15'h1000;
      @(posedge clk);
      ovr_load <= 1'b0;
      tick(1);
      mreg[0][31:21] = ovr_pm_cap_hi;
      mreg[1][3] = 1'b0;
      mreg[12] = {17'h0, ovr_replay};
      `CHK(replay_timeout, ovr_replay[11:0])
      rd_chk(8'h40);
      rd_chk(8'h44);
      rd_chk(8'h70);
      wake();
      final_report();
   end
endmodule : tb_port_capability_config_space

`default_nettype wire
